// ### design/ism_pkg.sv
// Shared constants and types for the two-wire serial memory slave.
//
// Behaviour
// - Answer only when received select bits equal the two strap pins.
// - An open select pin reads low through its pull-down.
// - Data line is open drain: pull low or release, never drive high.
// - Sample data on clock rise, change driven data on clock fall.
// - Protect input high blocks all array writes; low allows them.
// - Reads work whatever the protect input level.
// - An open protect input reads low, so writes are allowed.
// - Device is slave only; the master starts transfers and drives clock.
// - Data falling while clock high is a start; a transfer begins.
// - Data rising while clock high is a stop; device goes to standby.
// - Writes finish with no wait after stop; ready at once.
// - The receiver of a byte pulls data low on the ninth clock.
// - The sender of a byte releases data during the acknowledge clock.
// - A stop before the acknowledge aborts the operation to standby.
// - After a not-acknowledge is sent or received, release the bus.
// - A 9-bit address buffer supplies every array access location.
// - Write and random read take upper bit plus received low byte.
// - Current read takes received upper bit plus buffered low byte.
// - Address word: type code, high select, low select, upper, direction.
// - Direction bit zero means write, one means read.
// - Wrong type code or select bits: no access, go to standby.
// - Address steps after each data byte and wraps to zero.
package ism_pkg;

    localparam int unsigned ADDR_W = 9;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned MEM_WORDS = 512;
    localparam int unsigned CNT_W = 3;
    localparam int unsigned TYPE_W = 4;

    // Field positions inside the address word, most significant first.
    localparam int unsigned TYPE_MSB = 7;
    localparam int unsigned TYPE_LSB = 4;
    localparam int unsigned SEL_HIGH_POS = 3;
    localparam int unsigned SEL_LOW_POS = 2;
    localparam int unsigned UPPER_POS = 1;
    localparam int unsigned RW_POS = 0;

    localparam logic RW_READ = 1'h1;
    localparam logic ACK_LEVEL = 1'h0;
    localparam logic LINE_IDLE = 1'h1;
    localparam logic SDA_PULL = 1'h0;
    localparam logic FLAG_CLEAR = 1'h0;

    localparam logic [CNT_W-1:0] BIT_FIRST = 3'h0;
    localparam logic [CNT_W-1:0] BIT_LAST = 3'h7;
    localparam logic [CNT_W-1:0] BIT_STEP = 3'h1;

    localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 9'h001;
    localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;

    typedef enum logic [8:0] {
        ST_ADDR = 9'h001,
        ST_ADDR_ACK = 9'h002,
        ST_LOW = 9'h004,
        ST_LOW_ACK = 9'h008,
        ST_WDATA = 9'h010,
        ST_WDATA_ACK = 9'h020,
        ST_RDATA = 9'h040,
        ST_RDATA_ACK = 9'h080,
        ST_IGNORE = 9'h100
    } ism_state_t;

endpackage

// ### design/ism_mem.sv
// Byte-wide storage array with a registered read port.
`timescale 1ns/1ps
`default_nettype none

module ism_mem
(
    input wire logic clk,
    input wire logic wrEn,
    input wire logic [ism_pkg::ADDR_W-1:0] wrAddr,
    input wire logic [ism_pkg::DATA_W-1:0] wrData,
    input wire logic rdEn,
    input wire logic [ism_pkg::ADDR_W-1:0] rdAddr,
    output logic [ism_pkg::DATA_W-1:0] rdData
);

    logic [ism_pkg::DATA_W-1:0] cells [ism_pkg::MEM_WORDS];

    ////////////////////////////////////////////////////////////////////////
    // The array holds no reset; its contents are undefined at power-up.
    always_ff @(posedge clk)
    begin
        if (wrEn)
        begin
            cells[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rdEn)
        begin
            rdData <= cells[rdAddr];
        end
    end

endmodule

`default_nettype wire

// ### design/ism_slave_top.sv
// Two-wire slave front end of the 512 x 8 serial memory.
`timescale 1ns/1ps
`default_nettype none

module ism_slave_top
#(
    // Device type code expected in the address word; the value is arbitrary.
    parameter logic [ism_pkg::TYPE_W-1:0] TYPE_CODE = 4'h6
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic sclClk,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic addressSelectLowPin,
    input wire logic addressSelectHighPin,
    input wire logic writeProtect,
    output logic busBusy,
    output logic deviceSelected,
    output logic writeBlocked
);

    ////////////////////////////////////////////////////////////////////////
    // System clock side: start and stop detection by oversampling.

    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic sclLast;
    logic sdaLast;
    logic frameEvt;
    logic next_busBusy;
    logic selMeta;
    logic blkMeta;
    logic linkSelected;
    logic linkBlocked;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sclSync <= {2{ism_pkg::LINE_IDLE}};
            sdaSync <= {2{ism_pkg::LINE_IDLE}};
            sclLast <= ism_pkg::LINE_IDLE;
            sdaLast <= ism_pkg::LINE_IDLE;
        end
        else
        begin
            sclSync <= {sclSync[0], sclClk};
            sdaSync <= {sdaSync[0], sdaIn};
            sclLast <= sclSync[1];
            sdaLast <= sdaSync[1];
        end
    end

    // Both lines pass the same synchroniser depth, so their relative
    // order is kept and a data edge under a high clock is seen as such.
    wire clockHigh = sclSync[1] & sclLast;
    wire startSeen = clockHigh & sdaLast & ~sdaSync[1];
    wire stopSeen = clockHigh & ~sdaLast & sdaSync[1];

    assign next_busBusy = startSeen | (busBusy & ~stopSeen);

    // Status levels from the link side cross on two flip-flops each.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            frameEvt <= ism_pkg::FLAG_CLEAR;
            busBusy <= ism_pkg::FLAG_CLEAR;
            selMeta <= ism_pkg::FLAG_CLEAR;
            blkMeta <= ism_pkg::FLAG_CLEAR;
            deviceSelected <= ism_pkg::FLAG_CLEAR;
            writeBlocked <= ism_pkg::FLAG_CLEAR;
        end
        else
        begin
            frameEvt <= startSeen | stopSeen;
            busBusy <= next_busBusy;
            selMeta <= linkSelected;
            blkMeta <= linkBlocked;
            deviceSelected <= selMeta;
            writeBlocked <= blkMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link reset. A start or a stop restarts the byte engine at the
    // address word, so a stop before any acknowledge aborts the transfer
    // and a repeated start after a released bus begins a fresh one.
    // The pulse always ends while the serial clock is still high, so the
    // release never meets a rising edge; the master must hold the clock
    // high a few system cycles after a start or stop for this to hold.

    logic linkRst_b;

    assign linkRst_b = rst_b & ~frameEvt;

    ////////////////////////////////////////////////////////////////////////
    // Link side: strap and protect inputs pass two flip-flops.

    logic [2:0] pinMeta;
    logic [2:0] pinSync;

    // An open select or protect pin is held low by its pad pull-down, so
    // the core only ever sees a resolved level here.
    always_ff @(posedge sclClk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pinMeta <= {3{ism_pkg::FLAG_CLEAR}};
            pinSync <= {3{ism_pkg::FLAG_CLEAR}};
        end
        else
        begin
            pinMeta <= {writeProtect, addressSelectHighPin,
                        addressSelectLowPin};
            pinSync <= pinMeta;
        end
    end

    wire selLow = pinSync[0];
    wire selHigh = pinSync[1];
    wire protectOn = pinSync[2];

    ////////////////////////////////////////////////////////////////////////
    // Link side: byte engine, paced only by the master's clock.

    ism_pkg::ism_state_t state;
    ism_pkg::ism_state_t next_state;
    logic [ism_pkg::CNT_W-1:0] bitCnt;
    logic [ism_pkg::CNT_W-1:0] next_bitCnt;
    logic [ism_pkg::DATA_W-1:0] rxShift;
    logic [ism_pkg::ADDR_W-1:0] addrBuf;
    logic [ism_pkg::ADDR_W-1:0] next_addrBuf;
    logic [ism_pkg::DATA_W-1:0] memRdData;
    logic readReq;
    logic upperBit;

    // The data pin needs no synchroniser on this side: the master keeps it
    // steady while the clock is high, which is where it is sampled.
    wire [ism_pkg::DATA_W-1:0] rxByte = {rxShift[ism_pkg::DATA_W-2:0],
                                         sdaIn};

    wire inAddr = state == ism_pkg::ST_ADDR;
    wire inAddrAck = state == ism_pkg::ST_ADDR_ACK;
    wire inLow = state == ism_pkg::ST_LOW;
    wire inLowAck = state == ism_pkg::ST_LOW_ACK;
    wire inWData = state == ism_pkg::ST_WDATA;
    wire inWDataAck = state == ism_pkg::ST_WDATA_ACK;
    wire inRData = state == ism_pkg::ST_RDATA;
    wire inRDataAck = state == ism_pkg::ST_RDATA_ACK;
    wire lastBit = bitCnt == ism_pkg::BIT_LAST;

    wire receiving = inAddr | inLow | inWData;
    wire counting = receiving | inRData;

    // Address word decode.
    wire typeOk = rxByte[ism_pkg::TYPE_MSB:ism_pkg::TYPE_LSB]
                  == TYPE_CODE;
    wire selOk = (rxByte[ism_pkg::SEL_HIGH_POS] == selHigh)
                 & (rxByte[ism_pkg::SEL_LOW_POS] == selLow);
    wire addrHit = typeOk & selOk;
    wire rxRead = rxByte[ism_pkg::RW_POS] == ism_pkg::RW_READ;

    // Array accesses commit on the ninth rising edge only, so a stop that
    // lands before the acknowledge leaves memory untouched.
    wire masterAck = sdaIn == ism_pkg::ACK_LEVEL;
    wire readStep = (inAddrAck & readReq)
                    | (inRDataAck & masterAck);
    wire writeStep = inWDataAck;
    wire memWrEn = writeStep & ~protectOn;
    wire memStep = readStep | writeStep;

    // A read straight after the address word uses the new upper bit with
    // the buffered low byte; otherwise the buffer is used as it stands.
    wire [ism_pkg::ADDR_W-1:0] accAddr = inAddrAck
        ? {upperBit, addrBuf[ism_pkg::DATA_W-1:0]}
        : addrBuf;

    assign next_addrBuf = memStep ? accAddr + ism_pkg::ADDR_STEP
                        : inAddrAck ? accAddr
                        : inLowAck ? {upperBit, rxShift}
                        : addrBuf;

    assign next_bitCnt = counting ? bitCnt + ism_pkg::BIT_STEP
                                  : ism_pkg::BIT_FIRST;

    wire addrDone = inAddr & lastBit;
    wire [ism_pkg::DATA_W-1:0] next_rxShift = receiving ? rxByte : rxShift;
    wire next_readReq = addrDone ? rxRead : readReq;
    wire next_upperBit = addrDone ? rxByte[ism_pkg::UPPER_POS] : upperBit;
    wire next_linkSelected = linkSelected | (addrDone & addrHit);
    wire next_linkBlocked = linkBlocked | (writeStep & protectOn);

    always_comb
    begin
        next_state = state;
        unique case (state)
            ism_pkg::ST_ADDR:
            begin
                if (lastBit)
                begin
                    next_state = addrHit ? ism_pkg::ST_ADDR_ACK
                                         : ism_pkg::ST_IGNORE;
                end
            end
            ism_pkg::ST_ADDR_ACK:
            begin
                next_state = readReq ? ism_pkg::ST_RDATA
                                     : ism_pkg::ST_LOW;
            end
            ism_pkg::ST_LOW:
            begin
                if (lastBit)
                begin
                    next_state = ism_pkg::ST_LOW_ACK;
                end
            end
            ism_pkg::ST_LOW_ACK:
            begin
                next_state = ism_pkg::ST_WDATA;
            end
            ism_pkg::ST_WDATA:
            begin
                if (lastBit)
                begin
                    next_state = ism_pkg::ST_WDATA_ACK;
                end
            end
            ism_pkg::ST_WDATA_ACK:
            begin
                next_state = ism_pkg::ST_WDATA;
            end
            ism_pkg::ST_RDATA:
            begin
                if (lastBit)
                begin
                    next_state = ism_pkg::ST_RDATA_ACK;
                end
            end
            ism_pkg::ST_RDATA_ACK:
            begin
                next_state = masterAck ? ism_pkg::ST_RDATA
                                       : ism_pkg::ST_IGNORE;
            end
            ism_pkg::ST_IGNORE:
            begin
                next_state = ism_pkg::ST_IGNORE;
            end
            default:
            begin
                next_state = ism_pkg::ST_IGNORE;
            end
        endcase
    end

    // Everything here moves on the master's rising edge only; the block
    // never drives the clock and cannot start a transfer itself.
    always_ff @(posedge sclClk or negedge linkRst_b)
    begin
        if (!linkRst_b)
        begin
            state <= ism_pkg::ST_ADDR;
            bitCnt <= ism_pkg::BIT_FIRST;
            rxShift <= ism_pkg::BYTE_RESET;
        end
        else
        begin
            state <= next_state;
            bitCnt <= next_bitCnt;
            rxShift <= next_rxShift;
        end
    end

    // Status flags live for one frame; the set wins by construction since
    // only the frame reset clears them.
    always_ff @(posedge sclClk or negedge linkRst_b)
    begin
        if (!linkRst_b)
        begin
            readReq <= ism_pkg::FLAG_CLEAR;
            upperBit <= ism_pkg::FLAG_CLEAR;
            linkSelected <= ism_pkg::FLAG_CLEAR;
            linkBlocked <= ism_pkg::FLAG_CLEAR;
        end
        else
        begin
            readReq <= next_readReq;
            upperBit <= next_upperBit;
            linkSelected <= next_linkSelected;
            linkBlocked <= next_linkBlocked;
        end
    end

    // The address buffer survives starts and stops so that a current
    // address read continues from the last access.
    always_ff @(posedge sclClk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addrBuf <= ism_pkg::ADDR_RESET;
        end
        else
        begin
            addrBuf <= next_addrBuf;
        end
    end

    ism_mem u_mem
    (
        .clk(sclClk),
        .wrEn(memWrEn),
        .wrAddr(addrBuf),
        .wrData(rxShift),
        .rdEn(readStep),
        .rdAddr(accAddr),
        .rdData(memRdData)
    );

    ////////////////////////////////////////////////////////////////////////
    // Link side: data line driver, updated on the falling edge.

    wire ackSlot = inAddrAck | inLowAck | inWDataAck;
    wire [ism_pkg::CNT_W-1:0] txIdx = ism_pkg::BIT_LAST - bitCnt;
    wire txBit = memRdData[txIdx];

    // In the read acknowledge slot and in the ignore state the line is
    // left alone, so the master's answer can be sampled.
    wire next_sdaOe = ackSlot | (inRData & ~txBit);

    always_ff @(negedge sclClk or negedge linkRst_b)
    begin
        if (!linkRst_b)
        begin
            sdaOe <= ism_pkg::FLAG_CLEAR;
        end
        else
        begin
            sdaOe <= next_sdaOe;
        end
    end

    // The pin is only ever pulled low; the high level comes from the
    // external pull-up when the enable drops.
    always_ff @(negedge sclClk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sdaOut <= ism_pkg::SDA_PULL;
        end
        else
        begin
            sdaOut <= ism_pkg::SDA_PULL;
        end
    end

endmodule

`default_nettype wire

// ### verification/ism_slave_assertions.sv
// Port-level checks of the two-wire serial memory slave.
`timescale 1ns/1ps
`default_nettype none

module ism_slave_assertions
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic sclClk,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic addressSelectLowPin,
    input wire logic addressSelectHighPin,
    input wire logic writeProtect,
    input wire logic busBusy,
    input wire logic deviceSelected,
    input wire logic writeBlocked
);

default clocking cb @(posedge sys_clk); endclocking
default disable iff (!rst_b);

////////////////////////////////////////////////////////////////////////////
sequence s_start;
    sclClk && $past(sclClk) && $fell(sdaIn);
endsequence

sequence s_stop;
    sclClk && $past(sclClk) && $rose(sdaIn);
endsequence

property p_pull_only;
    sdaOut == ism_pkg::SDA_PULL;
endproperty
property p_oe_on_fall;
    $changed(sdaOe) |-> !sclClk;
endproperty
property p_idle_released;
    !busBusy |-> !sdaOe;
endproperty
property p_start_busy;
    s_start |-> ##[1:10] busBusy;
endproperty
property p_stop_idle;
    s_stop |-> ##[1:10] !busBusy;
endproperty
property p_stop_clears;
    s_stop |-> ##[1:12] (!deviceSelected && !writeBlocked);
endproperty
property p_start_clears;
    s_start |-> ##[1:12] !deviceSelected;
endproperty
property p_block_needs_wp;
    $rose(writeBlocked) |-> writeProtect;
endproperty
property p_sel_needs_busy;
    $rose(deviceSelected) |-> busBusy;
endproperty

////////////////////////////////////////////////////////////////////////////
a_pull_only: assert property (p_pull_only)
    else $error("data drive value is not low");
a_oe_on_fall: assert property (p_oe_on_fall)
    else $error("data enable moved while the clock was high");
a_idle_released: assert property (p_idle_released)
    else $error("data line held outside a frame");
a_start_busy: assert property (p_start_busy)
    else $error("start not seen as busy");
a_stop_idle: assert property (p_stop_idle)
    else $error("stop did not end busy");
a_stop_clears: assert property (p_stop_clears)
    else $error("status flags kept after stop");
a_start_clears: assert property (p_start_clears)
    else $error("selection kept after start");
a_block_needs_wp: assert property (p_block_needs_wp)
    else $error("write blocked without protect");
a_sel_needs_busy: assert property (p_sel_needs_busy)
    else $error("selected outside a frame");

endmodule

`default_nettype wire

// ### verification/ism_bus_master.sv
// Behavioural two-wire bus master that drives the serial clock.
`timescale 1ns/1ps
`default_nettype none

module ism_bus_master
(
    output logic sclClk,
    output logic sdaDrive,
    input wire logic sdaLine
);

localparam time QTR = 16;
localparam time HOLD = 40;

// The clock stands high between frames; only the master runs it.
initial
begin
    sclClk = 1'h1;
    sdaDrive = 1'h1;
end

////////////////////////////////////////////////////////////////////////////
// Long high phases leave the slave's sampler room to see the edge.
task automatic start_cond();
    sdaDrive = 1'h1;
    #QTR;
    sclClk = 1'h1;
    #HOLD;
    sdaDrive = 1'h0;
    #HOLD;
    sclClk = 1'h0;
endtask

task automatic stop_cond();
    sdaDrive = 1'h0;
    #QTR;
    sclClk = 1'h1;
    #HOLD;
    sdaDrive = 1'h1;
    #HOLD;
endtask

// Data moves only in the low phase; the line is sampled mid-high.
task automatic clock_bit(input logic val, output logic seen);
    sdaDrive = val;
    #QTR;
    sclClk = 1'h1;
    #QTR;
    seen = sdaLine;
    #QTR;
    sclClk = 1'h0;
    #QTR;
endtask

task automatic put_byte(input logic [7:0] b, output logic ackSeen);
    logic s;
    for (int i = 7; i >= 0; i--)
        clock_bit(b[i], s);
    clock_bit(1'h1, ackSeen);
endtask

task automatic get_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
        clock_bit(1'h1, b[i]);
    clock_bit(nack, s);
endtask

endmodule

`default_nettype wire

// ### verification/ism_slave_top_tb.sv
// Self-checking bench for the two-wire serial memory slave.
`timescale 1ns/1ps
`default_nettype none

module ism_slave_top_tb;

// Device type code; the value is arbitrary.
localparam logic [3:0] DEV_TYPE = 4'h6;
localparam realtime DRV = 1.3;

logic sys_clk;
logic rst_b;
logic sclClk;
logic sdaDrive;
logic sdaOut;
logic sdaOe;
logic addressSelectLowPin;
logic addressSelectHighPin;
logic writeProtect;
logic busBusy;
logic deviceSelected;
logic writeBlocked;
wire logic sdaLine;
int failures = 0;
int checkCount = 0;
logic [7:0] masks [3] = '{8'h80, 8'h08, 8'h04};
logic bitSeen;

// Open drain with pull-up: released means high.
assign sdaLine = (sdaOe ? sdaOut : 1'h1) & sdaDrive;

ism_slave_top #(.TYPE_CODE(DEV_TYPE)) DUT
(
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .sclClk(sclClk),
    .sdaIn(sdaLine),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .addressSelectLowPin(addressSelectLowPin),
    .addressSelectHighPin(addressSelectHighPin),
    .writeProtect(writeProtect),
    .busBusy(busBusy),
    .deviceSelected(deviceSelected),
    .writeBlocked(writeBlocked)
);

ism_bus_master M
(
    .sclClk(sclClk),
    .sdaDrive(sdaDrive),
    .sdaLine(sdaLine)
);

always #2.5 sys_clk = ~sys_clk;

////////////////////////////////////////////////////////////////////////////
task automatic stop_test();
    $display("checks %0d mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
endtask

task automatic check(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checkCount++;
    if (got !== exp)
    begin
        failures++;
        $display("mismatch %s expected %h seen %h", what, exp, got);
    end
endtask

function automatic logic [7:0] addr_word(logic [7:0] mask, logic up,
                                         logic rw);
    return {DEV_TYPE, 1'h1, 1'h0, up, rw} ^ mask;
endfunction

// A fractional offset keeps link edges off the system clock edges.
task automatic align();
    @(posedge sys_clk);
    #DRV;
endtask

task automatic send(input logic [7:0] b, input logic lvl, input string what);
    logic a;
    M.put_byte(b, a);
    check(what, {7'h0, lvl}, {7'h0, a});
endtask

task automatic recv(input logic [7:0] exp, input logic nack,
                    input string what);
    logic [7:0] d;
    M.get_byte(nack, d);
    check(what, exp, d);
endtask

task automatic set_ptr(input logic up, input logic [7:0] low);
    align();
    M.start_cond();
    send(addr_word(8'h00, up, 1'h0), 1'h0, "address ack");
    send(low, 1'h0, "low address ack");
endtask

task automatic read_start(input logic up);
    M.start_cond();
    send(addr_word(8'h00, up, 1'h1), 1'h0, "read address ack");
endtask

task automatic finish_frame();
    M.stop_cond();
    for (int n = 0; n < 20 && busBusy !== 1'h0; n++)
        align();
    check("busy after stop", 8'h00, {7'h0, busBusy});
    if (busBusy !== 1'h0)
        stop_test();
endtask

////////////////////////////////////////////////////////////////////////////
initial
begin
    repeat (100000) @(posedge sys_clk);
    failures++;
    $display("mismatch run length expected end seen hang");
    stop_test();
end

initial
begin
    sys_clk = 1'h0;
    rst_b = 1'h0;
    addressSelectLowPin = 1'h0;
    addressSelectHighPin = 1'h1;
    writeProtect = 1'h0;
    repeat (10) @(posedge sys_clk);
    #DRV rst_b = 1'h1;
    repeat (4) @(posedge sys_clk);
    set_ptr(1'h1, 8'hff);
    check("selected", 8'h01, {7'h0, deviceSelected});
    send(8'ha5, 1'h0, "data ack");
    send(8'h3c, 1'h0, "data ack after wrap");
    send(8'h96, 1'h0, "data ack");
    check("blocked", 8'h00, {7'h0, writeBlocked});
    finish_frame();
    $display("page write test done");
    set_ptr(1'h1, 8'hff);
    read_start(1'h1);
    recv(8'ha5, 1'h0, "random read");
    recv(8'h3c, 1'h1, "read after wrap");
    finish_frame();
    $display("random read test done");
    align();
    read_start(1'h0);
    recv(8'h96, 1'h1, "current read");
    finish_frame();
    $display("current read test done");
    align();
    writeProtect = 1'h1;
    set_ptr(1'h0, 8'h01);
    send(8'h11, 1'h0, "protected data ack");
    check("blocked", 8'h01, {7'h0, writeBlocked});
    finish_frame();
    set_ptr(1'h0, 8'h01);
    read_start(1'h0);
    recv(8'h96, 1'h1, "protected read");
    finish_frame();
    align();
    writeProtect = 1'h0;
    $display("write protect test done");
    // Each wrong field alone must leave the line released.
    for (int i = 0; i < 3; i++)
    begin
        align();
        M.start_cond();
        send(addr_word(masks[i], 1'h0, 1'h0), 1'h1, "foreign ack");
        check("foreign select", 8'h00, {7'h0, deviceSelected});
        finish_frame();
    end
    $display("address mismatch test done");
    set_ptr(1'h0, 8'h01);
    for (int i = 0; i < 4; i++)
        M.clock_bit(1'h0, bitSeen);
    finish_frame();
    set_ptr(1'h0, 8'h01);
    read_start(1'h0);
    recv(8'h96, 1'h1, "read after abort");
    finish_frame();
    $display("abort test done");
    stop_test();
end

endmodule

bind ism_slave_top ism_slave_assertions u_chk
(
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .sclClk(sclClk),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .addressSelectLowPin(addressSelectLowPin),
    .addressSelectHighPin(addressSelectHighPin),
    .writeProtect(writeProtect),
    .busBusy(busBusy),
    .deviceSelected(deviceSelected),
    .writeBlocked(writeBlocked)
);

`default_nettype wire
